// *** core/ssm_socket_map.sv ***
// Purpose: Register file mapping OUT stream identifiers onto sockets
// Assumes: Stream machines report state, misses and socket use per cycle
// Notes: Unmapped addresses read zero and ignore writes

// Functional notes
// - Sixteen status registers from 0xE0033680 capture unmapped ids.
// - Status bits 19:16 show the endpoint stream machine state.
// - Sixteen socket maps from 0xE00336C0 record endpoint and stream.
// - Endpoint in bits 19:16, stream id in 15:0 route streams to socket.
// - Enable bit 31 binds socket; same-numbered endpoint loses non-stream.
// - Bit 30 requests unmap; clearing it withdraws the request.
// - Released flag bit 29 rises once the stream machine stops using it.
module ssm_socket_map import ssm_pkg::*; #(
  parameter int unsigned NUM_EP = SSM_NUM_EP,
  parameter int unsigned NUM_SOCK = SSM_NUM_SOCK
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NUM_EP*4-1:0] ep_state,
  input wire ssm_miss_s [NUM_EP-1:0] ep_miss,
  input wire logic [NUM_SOCK-1:0] sock_busy,
  output ssm_binding_s [NUM_SOCK-1:0] sock_binding,
  output logic [NUM_EP-1:0] ep_nonstream_block
);

  // Index of a register inside a base-aligned window, or invalid
  function automatic logic [4:0] win_idx(input logic [31:0] a,
                                         input logic [31:0] base,
                                         input int unsigned n);
    logic [31:0] d;
    d = a - base;
    if (a >= base && d[1:0] == 2'b00 && (d >> 2) < n)
      win_idx = {1'b1, d[5:2]};
    else
      win_idx = 5'h00;
  endfunction

  logic [15:0] miss_id_reg [NUM_EP];
  logic [NUM_SOCK-1:0] en_reg;
  logic [NUM_SOCK-1:0] unmap_reg;
  logic [NUM_SOCK-1:0] released_reg;
  logic [3:0] ep_reg [NUM_SOCK];
  logic [15:0] sid_reg [NUM_SOCK];
  logic [31:0] rdata_next;

  // Address decode for both windows
  wire logic [4:0] st_hit = win_idx(reg_addr, SSM_STATUS_BASE, NUM_EP);
  wire logic [4:0] mp_hit = win_idx(reg_addr, SSM_MAP_BASE, NUM_SOCK);
  wire logic [3:0] st_sel = st_hit[3:0];
  wire logic [3:0] mp_sel = mp_hit[3:0];
  wire logic map_wr = reg_wr && mp_hit[4];

  // Capture the last unmapped stream id each endpoint asked for
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_EP; i++) miss_id_reg[i] <= 16'h0000;
    end else if (clk_en) begin
      for (int i = 0; i < NUM_EP; i++)
        if (ep_miss[i].valid)
          miss_id_reg[i] <= ep_miss[i].stream_id;
    end
  end

  // Socket mapping fields; firmware owns enable, unmap, endpoint, stream
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_reg <= '0;
      unmap_reg <= '0;
      for (int s = 0; s < NUM_SOCK; s++) begin
        ep_reg[s] <= 4'h0;
        sid_reg[s] <= 16'h0000;
      end
    end else if (clk_en && map_wr) begin
      en_reg[mp_sel] <= reg_wdata[SSM_ENABLE_BIT];
      unmap_reg[mp_sel] <= reg_wdata[SSM_UNMAP_BIT];
      ep_reg[mp_sel] <= reg_wdata[SSM_EP_LSB +: 4];
      sid_reg[mp_sel] <= reg_wdata[15:0];
    end
  end

  // Released flag follows an active unmap request once the socket is idle;
  // a withdrawn request drops it so the next request starts clean
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      released_reg <= '0;
    end else if (clk_en) begin
      for (int s = 0; s < NUM_SOCK; s++) begin
        if (!unmap_reg[s])
          released_reg[s] <= 1'b0;
        else if (!sock_busy[s])
          released_reg[s] <= 1'b1;
      end
    end
  end

  // Read mux; released is read-only, state comes straight from machines
  always_comb begin
    rdata_next = 32'h00000000;
    if (st_hit[4]) begin
      rdata_next[15:0] = miss_id_reg[st_sel];
      rdata_next[SSM_STATE_LSB +: 4] = ep_state[st_sel*4 +: 4];
    end else if (mp_hit[4]) begin
      rdata_next[SSM_ENABLE_BIT] = en_reg[mp_sel];
      rdata_next[SSM_UNMAP_BIT] = unmap_reg[mp_sel];
      rdata_next[SSM_RELEASED_BIT] = released_reg[mp_sel];
      rdata_next[SSM_EP_LSB +: 4] = ep_reg[mp_sel];
      rdata_next[15:0] = sid_reg[mp_sel];
    end
  end

  // Read data registered: stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) reg_rdata <= 32'h00000000;
    else if (clk_en) reg_rdata <= reg_rd ? rdata_next : 32'h00000000;
  end

  // Bindings to the stream machines, and non-stream lockout per endpoint
  always_comb begin
    ep_nonstream_block = '0;
    for (int s = 0; s < NUM_SOCK; s++) begin
      sock_binding[s].enable = en_reg[s];
      sock_binding[s].unmap_req = unmap_reg[s];
      sock_binding[s].bound_endpoint = ep_reg[s];
      sock_binding[s].stream_id = sid_reg[s];
      if (s < NUM_EP && en_reg[s]) ep_nonstream_block[s] = 1'b1;
    end
  end

  // The released flag may only be high under a live unmap request
  released_req_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && !unmap_reg[0] |=> !released_reg[0])
    else $error("released flag high without unmap request");

  // An idle socket under request must report release next cycle
  release_rise_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && unmap_reg[0] && !sock_busy[0] |=> released_reg[0])
    else $error("released flag did not rise on idle socket");

  // Writing zero to unmap clears the request
  unmap_clear_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && map_wr && !reg_wdata[SSM_UNMAP_BIT]
    |=> !unmap_reg[$past(mp_sel)])
    else $error("unmap withdrawal not honoured");

  // Enable written to a socket locks out the same endpoint
  enable_lock_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && map_wr && reg_wdata[SSM_ENABLE_BIT] && mp_sel == 4'h0
    |=> ep_nonstream_block[0])
    else $error("endpoint not locked out by enable");

  // Mapping fields route to socket binding
  bind_route_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && map_wr && mp_sel == 4'h1
    |=> sock_binding[1].stream_id == $past(reg_wdata[15:0]) &&
        sock_binding[1].bound_endpoint == $past(reg_wdata[19:16]))
    else $error("binding fields not routed");

  // Miss capture reaches the status register
  miss_capture_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && ep_miss[0].valid
    |=> miss_id_reg[0] == $past(ep_miss[0].stream_id))
    else $error("unmapped stream id not captured");

  // Status read shows the machine state one cycle later
  state_read_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == SSM_STATUS_BASE
    |=> reg_rdata[19:16] == $past(ep_state[3:0]))
    else $error("state not reported");

  // Mapping read returns written stream id
  map_read_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == SSM_MAP_BASE
    |=> reg_rdata[15:0] == $past(sid_reg[0]))
    else $error("mapping read mismatch");

  // Read data falls back to zero when no read was taken; a stale word
  // left on the bus would look like a second answer to the master
  rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero after idle cycle");

  // A low clock enable freezes the read data as well
  // so a stalled master still sees its answer
  rdata_freeze_a: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> $stable(reg_rdata))
    else $error("read data moved while clock enable low");

  // Enable bits hold while the block is frozen
  // otherwise a socket could be bound behind the stream machines' back
  enable_freeze_a: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> $stable(en_reg))
    else $error("enable bits moved while clock enable low");

  // Unmap requests hold while the block is frozen
  unmap_freeze_a: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> $stable(unmap_reg))
    else $error("unmap bits moved while clock enable low");

  // Released flags hold while the block is frozen
  // even if the socket goes idle meanwhile
  rel_freeze_a: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> $stable(released_reg))
    else $error("released flags moved while clock enable low");

  // Socket five carries the unmap handshake in the bench
  // so its flag is watched by itself as well as socket zero
  released_req5_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && !unmap_reg[5] |=> !released_reg[5])
    else $error("socket five released without request");

  // An idle socket five under request reports release next cycle
  release_rise5_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && unmap_reg[5] && !sock_busy[5] |=> released_reg[5])
    else $error("socket five release did not rise");

  // A busy socket not yet released must never claim release; firmware would then
  // rebind a stream that is still moving data
  release_hold5_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && sock_busy[5] && !released_reg[5] |=> !released_reg[5])
    else $error("busy socket reported released");

  // Enable written to socket five locks out endpoint five
  enable_lock5_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && map_wr && mp_sel == 4'h5
    |=> ep_nonstream_block[5] == $past(reg_wdata[SSM_ENABLE_BIT]))
    else $error("endpoint five lockout does not follow enable");

  // Writing one to the unmap bit raises the request
  unmap_set_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && map_wr && reg_wdata[SSM_UNMAP_BIT]
    |=> unmap_reg[$past(mp_sel)])
    else $error("unmap request not taken");

  // Socket five fields reach the stream machines
  bind_route5_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && map_wr && mp_sel == 4'h5
    |=> sock_binding[5].stream_id == $past(reg_wdata[15:0]) &&
        sock_binding[5].bound_endpoint == $past(reg_wdata[19:16]))
    else $error("socket five fields not routed");

  // The top endpoint captures its misses too
  // which catches an index that wraps short of the last endpoint
  miss_capture15_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && ep_miss[15].valid
    |=> miss_id_reg[15] == $past(ep_miss[15].stream_id))
    else $error("endpoint fifteen id not captured");

  // Without a miss the captured id stays put
  miss_hold_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && !ep_miss[0].valid |=> $stable(miss_id_reg[0]))
    else $error("captured id changed without miss");

  // The top endpoint's state nibble lands in its own status word
  state_read15_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == SSM_STATUS_BASE + 32'h0000003C
    |=> reg_rdata[19:16] == $past(ep_state[63:60]))
    else $error("endpoint fifteen state not reported");

  // Status words carry nothing above the state field
  status_top_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && reg_rd && st_hit[4] |=> reg_rdata[31:20] == 12'h000)
    else $error("status word has bits above state");

  // Released cannot be written: a write without unmap leaves it low
  // two cycles on, whatever bit 29 of the write data was
  released_ro_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && map_wr && !reg_wdata[SSM_UNMAP_BIT] ##1 clk_en
    |=> !released_reg[$past(mp_sel, 2)])
    else $error("released flag written by software");

  // Socket five reads back enable and stream id
  map_read5_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == SSM_MAP_BASE + 32'h00000014
    |=> reg_rdata[15:0] == $past(sid_reg[5]) &&
        reg_rdata[31] == $past(en_reg[5]))
    else $error("socket five read mismatch");

  // Reads outside both windows return zero
  unmapped_read_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && reg_rd && !st_hit[4] && !mp_hit[4]
    |=> reg_rdata == 32'h00000000)
    else $error("unmapped address read nonzero");

  // Writes outside the mapping window change no socket
  // status words are read-only, so they fall in here too
  refuse_write_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && reg_wr && !mp_hit[4]
    |=> $stable(en_reg) && $stable(unmap_reg))
    else $error("refused write changed a socket");

endmodule

// *** core/ssm_pkg.sv ***
// Purpose: Shared constants and types for the OUT stream socket map
// Assumes: 32-bit register words, byte addresses on the register port
// Notes: Offsets are full byte addresses; the whole 32-bit address decodes the window
package ssm_pkg;
  localparam int unsigned SSM_NUM_EP = 16;
  localparam int unsigned SSM_NUM_SOCK = 16;
  localparam logic [31:0] SSM_STATUS_BASE = 32'hE0033680;
  localparam logic [31:0] SSM_MAP_BASE = 32'hE00336C0;
  localparam logic [31:0] SSM_STRIDE = 32'h00000004;
  localparam logic [31:0] SSM_STATUS_RESET = 32'h00000000;
  localparam logic [31:0] SSM_MAP_RESET = 32'h00000000;
  localparam int unsigned SSM_STATE_LSB = 16;
  localparam int unsigned SSM_EP_LSB = 16;
  localparam int unsigned SSM_ENABLE_BIT = 31;
  localparam int unsigned SSM_UNMAP_BIT = 30;
  localparam int unsigned SSM_RELEASED_BIT = 29;

  // Stream machine state encodings, as reported in the status word
  typedef enum logic [3:0] {
    SSM_ST_NOT_CONFIGURED = 4'h0,
    SSM_ST_DISABLED = 4'h1,
    SSM_ST_PRIME_PIPE = 4'h2,
    SSM_ST_DEFERRED_PIPE_PRIMING = 4'h3,
    SSM_ST_IDLE = 4'h4,
    SSM_ST_START_STREAM = 4'h5,
    SSM_ST_MOVE_DATA = 4'h6,
    SSM_ST_END = 4'h7,
    SSM_ST_ERROR = 4'h8
  } ssm_state_e;

  // One socket binding as seen by the stream machines
  typedef struct packed {
    logic enable;
    logic unmap_req;
    logic [3:0] bound_endpoint;
    logic [15:0] stream_id;
  } ssm_binding_s;

  // One unmapped-stream report from an endpoint's stream machine
  typedef struct packed {
    logic valid;
    logic [15:0] stream_id;
  } ssm_miss_s;
endpackage

// *** tb/ssm_stream_side.sv ***
// Purpose: Stream machines and sockets on the far side of the socket map
// Assumes: The bench steers state, misses and socket use
// Notes: Miss pulses last one cycle, as a real machine's would
module ssm_stream_side import ssm_pkg::*; (
  input wire logic clk,
  input wire logic [3:0] st_cmd,
  input wire logic [4:0] miss_cmd,
  input wire logic [15:0] id_cmd,
  input wire logic [15:0] busy_cmd,
  output logic [63:0] ep_state,
  output ssm_miss_s [15:0] ep_miss,
  output logic [15:0] sock_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  // All machines share one state; a miss fires on one chosen endpoint
  always_ff @(posedge clk) begin
    ep_state <= {16{st_cmd}};
    sock_busy <= busy_cmd;
    for (int i = 0; i < 16; i++) begin
      ep_miss[i].valid <= miss_cmd[4] && (miss_cmd[3:0] == i[3:0]);
      ep_miss[i].stream_id <= id_cmd;
    end
  end
endmodule

// *** tb/superspeed_out_stream_socket_map_tb.sv ***
// Purpose: Self-checking bench for the OUT stream socket map
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: Random values come from a 16-bit LFSR seeded at 78
module superspeed_out_stream_socket_map_tb;
  import ssm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, cen = 1;
  logic [31:0] addr = '0, wdata = '0, rdata, e, m5;
  logic [3:0] st = '0;
  logic [4:0] mc = '0;
  logic [15:0] idc = '0, busy = '0, lf = 16'h004E, id, sbusy, nsb;
  logic [63:0] eps;
  ssm_miss_s [15:0] miss;
  ssm_binding_s [15:0] bnd;
  int err_total = 0, check_count = 0, n, k;
  ssm_socket_map dut (.clk(clk), .rst(rst), .clk_en(cen),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .ep_state(eps), .ep_miss(miss),
    .sock_busy(sbusy), .sock_binding(bnd), .ep_nonstream_block(nsb));
  ssm_stream_side far (.clk(clk), .st_cmd(st), .miss_cmd(mc),
    .id_cmd(idc), .busy_cmd(busy), .ep_state(eps), .ep_miss(miss),
    .sock_busy(sbusy));
  initial forever #12.5 clk = ~clk;
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // One-cycle strobes; the next access waits for a fresh edge
  task automatic wrt(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [31:0] a, input logic [31:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, x);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    complete_run;
  end
  initial begin
    m5 = SSM_MAP_BASE + 32'h14;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdr(SSM_STATUS_BASE + 32'h3C, SSM_STATUS_RESET);
    rdr(SSM_MAP_BASE, SSM_MAP_RESET);
    $display("reset test done");
    // Every machine state, each with a miss on a random endpoint
    for (k = 0; k < 9; k++) begin
      lf = nxt(lf);
      n = int'(lf[3:0]);
      @(posedge clk);
      st <= k[3:0];
      mc <= {1'b1, lf[3:0]};
      idc <= lf;
      @(posedge clk);
      mc <= 5'h00;
      repeat (2) @(posedge clk);
      rdr(SSM_STATUS_BASE + 32'(4 * n),
          {12'h000, k[3:0], lf});
    end
    id = lf;
    $display("status test done");
    // Random bindings; a written released bit must not stick
    for (k = 0; k < 16; k++) begin
      lf = nxt(lf);
      e = {k[0], 11'h000, lf[3:0], lf};
      wrt(SSM_MAP_BASE + 32'(4 * k), e | 32'h2000_0000);
      rdr(SSM_MAP_BASE + 32'(4 * k), e);
      chk({10'h000, bnd[k]}, {10'h000, e[31], 1'b0, e[19:0]});
      chk({31'h0, nsb[k]}, {31'h0, e[31]});
    end
    $display("mapping test done");
    // Unmap held off by a busy socket, then withdrawn after 200 ns
    e = 32'h8003_1234;
    @(posedge clk);
    busy <= 16'hFFFF;
    wrt(m5, e);
    wrt(m5, e | 32'h4000_0000);
    repeat (4) @(posedge clk);
    rdr(m5, e | 32'h4000_0000);
    wrt(m5, e);
    rdr(m5, e);
    // Retry with the socket free: released must rise, then fall
    @(posedge clk);
    busy <= 16'h0000;
    wrt(m5, e | 32'h4000_0000);
    repeat (2) @(posedge clk);
    rdr(m5, e | 32'h6000_0000);
    chk({10'h000, bnd[5]}, {10'h000, 2'b11, e[19:0]});
    wrt(m5, e);
    rdr(m5, e);
    $display("unmap test done");
    // Read-only status, misaligned and unmapped places
    wrt(SSM_STATUS_BASE + 32'(4 * n), 32'hFFFF_FFFF);
    rdr(SSM_STATUS_BASE + 32'(4 * n), {12'h000, 4'h8, id});
    wrt(m5 + 32'h2, 32'hFFFF_FFFF);
    rdr(m5, e);
    rdr(32'hE003_3700, 32'h0);
    $display("refusal test done");
    // Clock enable low: a write in that cycle must not land
    @(posedge clk);
    cen <= 1'b0;
    wrt(m5, 32'h0000_0000);
    @(posedge clk);
    cen <= 1'b1;
    rdr(m5, e);
    $display("enable test done");
    complete_run;
  end
endmodule
